// File: hw/dsb_pkg.sv
// Package of constants for the serial double-buffered converter interface.
package dsb_pkg;
  localparam int          WORD_W       = 16;
  localparam logic [15:0] LATCH_RESET  = 16'h0000;
  localparam int          SYNC_STAGES  = 3;
  localparam int          FIFO_DEPTH   = 8;
  // Enable pattern codes, {input enable_n, conversion enable_n}.
  typedef enum logic [1:0] {
    DSB_MODE_TWO_WIRE = 2'b00,
    DSB_MODE_SHIFT    = 2'b01,
    DSB_MODE_LOAD     = 2'b10,
    DSB_MODE_IDLE     = 2'b11
  } dsb_mode_t;
endpackage : dsb_pkg

// File: hw/dsb_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
module dsb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  // Depths that are not a power of two would break the wrap-bit full test.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("dsb_fifo DEPTH must be a power of two, two or more");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;
  logic [AW:0]      rd_next;

  // Full when pointers differ only in the wrap bit.
  assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign rd_next   = rd_q + {{AW{1'b0}}, pop};

  // Storage is written only on accepted pushes.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers advance on handshakes.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  // Read data come from a register that already holds the word at the next read slot.
  // A push into that very slot, as into an empty queue, is forwarded past the memory.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_data <= '0;
    end else if (push && (wr_q[AW-1:0] == rd_next[AW-1:0])) begin
      out_data <= in_data;
    end else begin
      out_data <= mem_q[rd_next[AW-1:0]];
    end
  end
endmodule : dsb_fifo

// File: hw/dsb_core.sv
// Serial input interface with double-buffered latches for a 16-bit converter.
// What this block does
// R1 - Input latch word moves to conversion latch.
// R2 - All control inputs active low.
// R3 - Latches pass when enable low, hold high.
// R4 - Clear zeroes both latches once the synchronised and filtered clear level goes low.
// R5 - Words are unsigned straight binary.
// R6 - Serial words arrive most significant bit first.
// R7 - Undriven inputs have no pull-down; only reset and clear load zero into the latches.
// R8 - Code zero means zero output, monotonic.
// R9 - Enable pattern per clock cycle selects action.
// R10 - Both enables low: two-wire pass-through.
// R11 - Shift register end appears on cascade output.
// R12 - Shift on rising link clock edge.
module dsb_core
  import dsb_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      link_clk,
  input  wire logic                      serial_in,
  input  wire logic                      input_latch_enable_n,
  input  wire logic                      conversion_latch_enable_n,
  input  wire logic                      latch_clear_n,
  output logic                           serial_cascade_out,
  output logic      [dsb_pkg::WORD_W-1:0] conv_code,
  output logic                           conv_valid,
  input  wire logic                      conv_ready,
  output logic      [dsb_pkg::WORD_W-1:0] input_word
);
  import dsb_pkg::*;

  // The pin filter is written for exactly three stages, and the shift needs two bits or more.
  if (SYNC_STAGES != 3 || WORD_W < 2) begin : g_bad_config
    $error("dsb_core needs three synchroniser stages and a word of two bits or more");
  end

  // Three-stage synchronisers: one per pin; a change counts when stages 2 and 3 agree.
  logic [SYNC_STAGES-1:0] s_clk_q, s_din_q, s_en0_q, s_en1_q, s_clr_q;
  logic                   lclk_q, din_q, en0_q, en1_q, clr_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_clk_q <= '1; // Idle high, so no false edge follows reset.
      s_din_q <= '0;
      s_en0_q <= '1;
      s_en1_q <= '1;
      s_clr_q <= '1;
    end else begin
      s_clk_q <= {s_clk_q[1:0], link_clk};
      s_din_q <= {s_din_q[1:0], serial_in};
      s_en0_q <= {s_en0_q[1:0], input_latch_enable_n};
      s_en1_q <= {s_en1_q[1:0], conversion_latch_enable_n};
      s_clr_q <= {s_clr_q[1:0], latch_clear_n};
    end
  end

  // Filtered levels update only when stages 2 and 3 agree.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lclk_q <= 1'b1;
      din_q  <= 1'b0;
      en0_q  <= 1'b1;
      en1_q  <= 1'b1;
      clr_q  <= 1'b1;
    end else begin
      if (s_clk_q[1] == s_clk_q[2]) lclk_q <= s_clk_q[2];
      if (s_din_q[1] == s_din_q[2]) din_q <= s_din_q[2];
      if (s_en0_q[1] == s_en0_q[2]) en0_q <= s_en0_q[2];
      if (s_en1_q[1] == s_en1_q[2]) en1_q <= s_en1_q[2];
      if (s_clr_q[1] == s_clr_q[2]) clr_q <= s_clr_q[2];
    end
  end

  // Rising edge of the filtered link clock closes one low-high cycle.
  logic lclk_prev_q;
  logic rise;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) lclk_prev_q <= 1'b1;
    else lclk_prev_q <= lclk_q;
  end
  assign rise = lclk_q && !lclk_prev_q; // R12

  dsb_mode_t mode;
  assign mode = dsb_mode_t'({en0_q, en1_q}); // R2

  // Input shift latch: MSB first, new bits enter at the bottom.
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] shift_d;
  always_comb begin
    shift_d = shift_q;
    case (mode)
      DSB_MODE_SHIFT,
      DSB_MODE_TWO_WIRE: begin
        if (rise) shift_d = {shift_q[WORD_W-2:0], din_q}; // R6 R9 R3
      end
      default: shift_d = shift_q;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) shift_q <= LATCH_RESET; // R7
    else if (!clr_q) shift_q <= LATCH_RESET; // R4
    else shift_q <= shift_d;
  end

  // Conversion latch: loads on a cycle with its enable low, or follows in two-wire mode.
  logic [WORD_W-1:0] conv_q;
  logic              load;
  logic              fifo_ready;
  always_comb begin
    case (mode)
      DSB_MODE_LOAD:     load = rise; // R1 R9
      DSB_MODE_TWO_WIRE: load = rise; // R10
      default:           load = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) conv_q <= LATCH_RESET;
    else if (!clr_q) conv_q <= LATCH_RESET; // R4
    else if (load && mode == DSB_MODE_TWO_WIRE) conv_q <= shift_d; // R10
    else if (load) conv_q <= shift_q; // R1 R5
  end

  // Conversion updates are queued to the analog side; while the queue is full only one update waits,
  // it takes the newest latch value when the queue frees, and the updates in between are dropped.
  logic clr_prev_q;
  logic push;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) clr_prev_q <= 1'b1;
    else clr_prev_q <= clr_q;
  end
  logic pend_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) pend_q <= 1'b0;
    else if (load || (clr_prev_q && !clr_q)) pend_q <= 1'b1;
    else if (fifo_ready) pend_q <= 1'b0;
  end
  assign push = pend_q;

  dsb_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .in_data  (conv_q),      // R8
    .in_valid (push),
    .in_ready (fifo_ready),
    .out_data (conv_code),
    .out_valid(conv_valid),
    .out_ready(conv_ready)
  );

  // Cascade end and latch view come from flip-flops.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_cascade_out <= 1'b0;
      input_word         <= LATCH_RESET;
    end else begin
      serial_cascade_out <= shift_q[WORD_W-1]; // R11
      input_word         <= shift_q;
    end
  end

  // Clear checks: the clear dominates the enables and queues one zero code.
  chk_clear_zeroes: assert property (@(posedge clk) disable iff (!reset_n) // R4
    !clr_q |=> (shift_q == '0 && conv_q == '0))
    else $error("Clear did not zero both latches.");
  chk_clear_queued: assert property (@(posedge clk) disable iff (!reset_n) // R4
    (clr_prev_q && !clr_q) |=> (pend_q && conv_q == '0))
    else $error("Clear did not queue a zero code.");
  // Input latch checks: it moves only on a qualifying rise, one bit in at the bottom.
  chk_shift_msb: assert property (@(posedge clk) disable iff (!reset_n) // R6
    (rise && clr_q && mode == DSB_MODE_SHIFT) |=>
      shift_q == {$past(shift_q[WORD_W-2:0]), $past(din_q)})
    else $error("Shift did not enter at the bottom.");
  chk_shift_hold: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (clr_q && !rise) |=> $stable(shift_q))
    else $error("Input latch moved without a rise.");
  chk_no_shift_load: assert property (@(posedge clk) disable iff (!reset_n) // R12
    (clr_q && mode == DSB_MODE_LOAD) |=> $stable(shift_q))
    else $error("Input latch moved during a load.");
  chk_hold_idle: assert property (@(posedge clk) disable iff (!reset_n) // R9
    (clr_q && mode == DSB_MODE_IDLE) |=> $stable(conv_q) && $stable(shift_q))
    else $error("Idle pattern changed a latch.");
  // Conversion latch checks: it moves only on a load or two-wire rise, each move queued.
  chk_load_copy: assert property (@(posedge clk) disable iff (!reset_n) // R1
    (rise && clr_q && mode == DSB_MODE_LOAD) |=> conv_q == $past(shift_q))
    else $error("Load did not copy the input latch.");
  chk_load_queued: assert property (@(posedge clk) disable iff (!reset_n) // R1
    load |=> pend_q)
    else $error("Load was not queued.");
  chk_pend_kept: assert property (@(posedge clk) disable iff (!reset_n) // R1
    (pend_q && !fifo_ready) |=> pend_q)
    else $error("Pending update lost while the queue was full.");
  chk_conv_hold: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (clr_q && !rise) |=> $stable(conv_q))
    else $error("Conversion latch moved without a rise.");
  chk_shift_no_load: assert property (@(posedge clk) disable iff (!reset_n) // R9
    (clr_q && mode == DSB_MODE_SHIFT) |=> $stable(conv_q))
    else $error("Conversion latch moved during a shift.");
  chk_two_wire: assert property (@(posedge clk) disable iff (!reset_n) // R10
    (rise && clr_q && mode == DSB_MODE_TWO_WIRE) |=> conv_q == shift_q)
    else $error("Two-wire rise did not pass the word through.");
  // Output and pin filter checks.
  chk_cascade_end: assert property (@(posedge clk) disable iff (!reset_n) // R11
    1'b1 |=> serial_cascade_out == $past(shift_q[WORD_W-1]))
    else $error("Cascade output does not follow the top bit.");
  chk_word_view: assert property (@(posedge clk) disable iff (!reset_n) // R1
    1'b1 |=> input_word == $past(shift_q))
    else $error("Input word view does not follow the latch.");
  chk_clr_filter: assert property (@(posedge clk) disable iff (!reset_n) // R2
    (s_clr_q[1] != s_clr_q[2]) |=> $stable(clr_q))
    else $error("Clear level changed while its stages disagreed.");
  chk_clk_filter: assert property (@(posedge clk) disable iff (!reset_n) // R12
    (s_clk_q[1] != s_clk_q[2]) |=> $stable(lclk_q))
    else $error("Link clock level changed while its stages disagreed.");

  // Scenarios worth seeing at least once: the shift, load and two-wire patterns, a clear and a full queue.
  cov_shift: cover property (@(posedge clk) rise && mode == DSB_MODE_SHIFT);
  cov_load: cover property (@(posedge clk) rise && mode == DSB_MODE_LOAD);
  cov_two_wire: cover property (@(posedge clk) rise && mode == DSB_MODE_TWO_WIRE);
  cov_clear: cover property (@(posedge clk) !clr_q);
  cov_full: cover property (@(posedge clk) !fifo_ready);
endmodule : dsb_core

// File: bench/dsb_host.sv
// Host model that drives the serial clock, data, enables and clear pins.
module dsb_host (
  input  wire logic clk,
  output logic      link_clk,
  output logic      serial_in,
  output logic      input_latch_enable_n,
  output logic      conversion_latch_enable_n,
  output logic      latch_clear_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Outside frames the serial clock stands high and every control is inactive.
  initial begin
    link_clk = 1'b1;
    serial_in = 1'b0;
    {input_latch_enable_n, conversion_latch_enable_n} = 2'b11;
    latch_clear_n = 1'b1;
  end
  // One low-high serial clock cycle of 80 ns with an enable pattern and a data bit.
  task automatic beat(input logic [1:0] mode, input logic bit_v);
    @(posedge clk) #1;
    {input_latch_enable_n, conversion_latch_enable_n} = mode;
    serial_in = bit_v;
    link_clk = 1'b0;
    repeat (4) @(posedge clk);
    #1 link_clk = 1'b1;
    repeat (3) @(posedge clk);
    // Hold time has run out, so the data line shows the inverse, not a stale bit.
    #1 serial_in = ~bit_v;
    {input_latch_enable_n, conversion_latch_enable_n} = 2'b11;
  endtask : beat
  // A whole unsigned word, top bit first.
  task automatic word(input logic [15:0] w, input logic [1:0] mode);
    for (int i = 15; i >= 0; i--) begin
      beat(mode, w[i]);
    end
  endtask : word
  // Clear pulse of 200 ns, driven low to assert it.
  task automatic clear();
    @(posedge clk) #1 latch_clear_n = 1'b0;
    repeat (20) @(posedge clk);
    #1 latch_clear_n = 1'b1;
  endtask : clear
endmodule : dsb_host

// File: bench/dsb_core_tb.sv
// Self-checking testbench for the serial double-buffered converter interface.
module dsb_core_tb;
  import dsb_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk, reset_n, conv_ready, conv_valid, serial_cascade_out;
  logic              link_clk, serial_in, latch_clear_n;
  logic              input_latch_enable_n, conversion_latch_enable_n;
  logic [WORD_W-1:0] conv_code, input_word;
  int                n_mismatch, checked, cycles;
  dsb_host host (.clk(clk), .link_clk(link_clk), .serial_in(serial_in),
    .input_latch_enable_n(input_latch_enable_n), .latch_clear_n(latch_clear_n),
    .conversion_latch_enable_n(conversion_latch_enable_n));
  dsb_core dut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .serial_in(serial_in),
    .input_latch_enable_n(input_latch_enable_n), .latch_clear_n(latch_clear_n),
    .conversion_latch_enable_n(conversion_latch_enable_n), .conv_valid(conv_valid),
    .serial_cascade_out(serial_cascade_out), .conv_code(conv_code),
    .conv_ready(conv_ready), .input_word(input_word));
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A hang is cut short at 5000 cycles, several times what the scenarios need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Waits a bounded time for a queued snapshot, compares it, then pops it.
  task automatic pop(input logic [WORD_W-1:0] exp);
    for (int n = 0; n < 50 && conv_valid !== 1'b1; n++) begin
      @(posedge clk) #1;
    end
    check({15'h0000, conv_valid}, 16'h0001);
    check(conv_code, exp);
    conv_ready = 1'b1;
    @(posedge clk) #1 conv_ready = 1'b0;
  endtask : pop
  task automatic t_shift();
    host.word(16'ha5c3, DSB_MODE_SHIFT);
    repeat (8) @(posedge clk);
    #1 check(input_word, 16'ha5c3);
    check({15'h0000, serial_cascade_out}, 16'h0001);
    check({15'h0000, conv_valid}, 16'h0000);
    host.beat(DSB_MODE_IDLE, 1'b0);
    host.beat(DSB_MODE_IDLE, 1'b0);
    repeat (8) @(posedge clk);
    #1 check(input_word, 16'ha5c3);
    check({15'h0000, conv_valid}, 16'h0000);
    host.beat(DSB_MODE_LOAD, 1'b0);
    pop(16'ha5c3);
    $display("shift and load test done");
  endtask : t_shift
  task automatic t_clear();
    host.clear();
    repeat (8) @(posedge clk);
    #1 check(input_word, LATCH_RESET);
    pop(LATCH_RESET);
    host.beat(DSB_MODE_LOAD, 1'b1);
    pop(LATCH_RESET);
    $display("clear test done");
  endtask : t_clear
  // Two-wire traffic with the consumer stalled: eight queue, then only the newest waits.
  task automatic t_two_wire();
    host.word(16'hb2c5, DSB_MODE_TWO_WIRE);
    repeat (4) @(posedge clk) #1; // Let the last load land before the first pop.
    for (int k = 1; k <= 8; k++) begin
      pop(16'hb2c5 >> (16 - k));
    end
    pop(16'hb2c5);
    repeat (10) @(posedge clk);
    #1 check({15'h0000, conv_valid}, 16'h0000);
    check(input_word, 16'hb2c5);
    $display("two-wire and buffer test done");
  endtask : t_two_wire
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // Reset for ten cycles, then the scenarios in turn.
  initial begin
    reset_n = 1'b0;
    conv_ready = 1'b0;
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 check({15'h0000, conv_valid}, 16'h0000);
    check(input_word, LATCH_RESET);
    t_shift();
    t_clear();
    t_two_wire();
    results();
  end
endmodule : dsb_core_tb
